// ### shared/mirb_pkg.sv
// constants and layouts shared by the instrument register bank
package mirb_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 125000000;          // 8 ns period
   localparam int unsigned HOUR_S          = 3600;               // one service hour
   localparam logic [39:0] HOUR_CYCLES     = 40'(64'(CLK_HZ) * 64'(HOUR_S));
   localparam int unsigned SERIAL_BAUD     = 57600;              // bits per second
   localparam logic [11:0] BAUD_CYCLES     = 12'(CLK_HZ / SERIAL_BAUD);
   localparam int unsigned SERIAL_DATA_BITS = 8;
   localparam int unsigned SERIAL_STOP_BITS = 1;
   localparam logic        SERIAL_PARITY_EVEN = 1'b1;
   localparam int unsigned TCP_SERVICE_PORT = 502;

   // ---------------------------------------------------------------
   // register tables and offsets
   // ---------------------------------------------------------------
   localparam logic [1:0]  TBL_COIL        = 2'h0;
   localparam logic [1:0]  TBL_DISCRETE    = 2'h1;
   localparam logic [1:0]  TBL_HOLDING     = 2'h2;
   localparam logic [1:0]  TBL_INPUT       = 2'h3;

   localparam logic [15:0] COIL_RESET_WARN    = 16'h0000;
   localparam logic [15:0] COIL_PUMP_STANDBY  = 16'h0001;
   localparam logic [15:0] COIL_SVC_RESTART   = 16'h0002;
   localparam logic [15:0] COIL_WARN_HOLD     = 16'h0003;
   localparam logic [15:0] COIL_CTRL_RESTART  = 16'h0004;
   localparam logic [15:0] COIL_LAST          = 16'h0004;

   localparam logic [15:0] DI_SVC_REMINDER    = 16'h0000;
   localparam logic [15:0] DI_LAST            = 16'h0006;   // 1..6 from warning inputs

   localparam logic [15:0] HOLD_NODE_ADDR     = 16'h0000;

   localparam logic [15:0] IR_TANK_PRESSURE   = 16'h0000;
   localparam logic [15:0] IR_OUTLET_PRESSURE = 16'h0002;
   localparam logic [15:0] IR_SCRUB_TEMP      = 16'h0004;
   localparam logic [15:0] IR_ENCL_TEMP       = 16'h0006;
   localparam logic [15:0] IR_PUMP_DUTY       = 16'h0008;
   localparam logic [15:0] IR_HEATER_DUTY     = 16'h000a;
   localparam logic [15:0] IR_SVC_HOURS       = 16'h000c;
   localparam logic [15:0] IR_REF_VOLTAGE     = 16'h000e;
   localparam logic [15:0] IR_MODEL_CODE      = 16'h001e;
   localparam logic [15:0] IR_UNIT_SERIAL     = 16'h0020;
   localparam logic [15:0] IR_FW_PART         = 16'h0022;
   localparam logic [15:0] IR_FW_VERSION      = 16'h0024;

   // ---------------------------------------------------------------
   // values, reset values and exception answers
   // ---------------------------------------------------------------
   localparam logic [7:0]  NODE_ADDR_MIN   = 8'h01;
   localparam logic [7:0]  NODE_ADDR_MAX   = 8'hf7;              // 247
   localparam logic [7:0]  NODE_ADDR_RST   = 8'h01;
   localparam logic        RESET_WARN_RST  = 1'b1;
   localparam logic [15:0] SVC_HOURS_DFLT  = 16'h03e8;           // plain default
   localparam logic [7:0]  EXC_NONE        = 8'h00;
   localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
   localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;
   localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;

endpackage : mirb_pkg

// ### design/mirb_register_bank.sv
// instrument register bank behind the remote master's request port
//
// Behaviour
// - five read/write coils at addresses 0 to 4
// - seven read-only discrete inputs at addresses 0 to 6
// - holding register 0 keeps the node address; only 1 to 247 accepted
// - input registers are 32-bit floats, two words each, even addresses
// - pump and heater duty read as fractions, 1.0 meaning full duty
// - a controller restart or power-up sets the reset warning coil to 1
// - reset warning clears on a written 0 or at end of warm-up
// - while the hold coil is 1, warm-up end leaves the warning set
// - writing 1 to the standby coil stops the pump, heaters keep running
// - writing 0 to the standby coil resumes normal pump operation
// - service timer counts operating hours left, read as a float
// - service reminder input reads 1 once the timer reaches zero
// - writing 1 to the service restart coil clears reminder, reloads timer
// - node address resets to 1 and a new value applies at once
// - serial link defaults to 57600 baud, 8 data bits, even, 1 stop
// - only one transport, serial or network, is enabled at a time
`timescale 1ns/1ps
module mirb_register_bank #(
   parameter logic [39:0] HOUR_CYCLES  = mirb_pkg::HOUR_CYCLES,
   parameter logic [15:0] SVC_HOURS    = mirb_pkg::SVC_HOURS_DFLT,
   parameter logic [31:0] MODEL_CODE   = 32'h00000001,   // arbitrary value
   parameter logic [31:0] UNIT_SERIAL  = 32'h00000002,   // arbitrary value
   parameter logic [31:0] FW_PART      = 32'h00000003,   // arbitrary value
   parameter logic [31:0] FW_VERSION   = 32'h3f800000    // arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [1:0]  req_table,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_wdata,
   output logic             rsp_valid,
   output logic [15:0]      rsp_data,
   output logic [7:0]       rsp_exc,
   input  wire logic        warmup_end,
   input  wire logic [5:0]  warn_in,
   input  wire logic        transport_net,
   input  wire logic [31:0] tank_pressure,
   input  wire logic [31:0] outlet_pressure,
   input  wire logic [31:0] scrub_temp,
   input  wire logic [31:0] encl_temp,
   input  wire logic [31:0] pump_duty,
   input  wire logic [31:0] heater_duty,
   input  wire logic [31:0] ref_voltage,
   output logic             pump_enable,
   output logic             ctrl_restart,
   output logic [7:0]       node_address,
   output logic             serial_enable,
   output logic             net_enable,
   output logic             serial_bit_tick,
   output logic             reset_warning,
   output logic             service_reminder
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        rsp_valid;
      logic [15:0] rsp_data;
      logic [7:0]  rsp_exc;
      logic        reset_warn;
      logic        warn_hold;
      logic        standby;
      logic        pump_en;
      logic [7:0]  node_addr;
      logic [15:0] hours_left;
      logic        reminder;
      logic [39:0] hour_cnt;
      logic [5:0]  warn;
      logic        restart;
      logic        serial_en;
      logic        net_en;
      logic [11:0] baud_cnt;
      logic        baud_tick;
   } mirb_state_t;

   mirb_state_t st_ff;
   mirb_state_t nxt_st;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // whole hours to single float; exact since 16 bits fit the mantissa
   function automatic logic [31:0] mirb_u16_to_f32(input logic [15:0] v);
      logic [4:0]  msb;
      logic [38:0] sh;
      msb = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            msb = 5'(i);
         end
      end
      sh = {23'h000000, v} << (5'd23 - msb);
      if (v == 16'h0000) begin
         return 32'h00000000;
      end
      return {1'b0, 8'(8'd127 + {3'h0, msb}), sh[22:0]};
   endfunction : mirb_u16_to_f32

   logic [31:0] rd_word;       // selected 32-bit input value
   logic        rd_word_ok;
   logic [15:0] even_addr;
   logic        wr_coil;
   logic        wr_hold;
   logic        restart_evt;
   logic [6:0]  di_bits;       // discrete inputs, reminder at address 0

   // input register pair select; high word sits at the even address
   always_comb begin
      even_addr  = {req_addr[15:1], 1'b0};
      rd_word    = 32'h00000000;
      rd_word_ok = 1'b1;
      unique case (even_addr)
         mirb_pkg::IR_TANK_PRESSURE:   rd_word = tank_pressure;
         mirb_pkg::IR_OUTLET_PRESSURE: rd_word = outlet_pressure;
         mirb_pkg::IR_SCRUB_TEMP:      rd_word = scrub_temp;
         mirb_pkg::IR_ENCL_TEMP:       rd_word = encl_temp;
         mirb_pkg::IR_PUMP_DUTY:       rd_word = pump_duty;
         mirb_pkg::IR_HEATER_DUTY:     rd_word = heater_duty;
         mirb_pkg::IR_SVC_HOURS:       rd_word = mirb_u16_to_f32(st_ff.hours_left);
         mirb_pkg::IR_REF_VOLTAGE:     rd_word = ref_voltage;
         mirb_pkg::IR_MODEL_CODE:      rd_word = MODEL_CODE;
         mirb_pkg::IR_UNIT_SERIAL:     rd_word = UNIT_SERIAL;
         mirb_pkg::IR_FW_PART:         rd_word = FW_PART;
         mirb_pkg::IR_FW_VERSION:      rd_word = FW_VERSION;
         default:                      rd_word_ok = 1'b0;
      endcase
   end

   assign di_bits = {st_ff.warn, st_ff.reminder};
   assign wr_coil = req_valid && req_write && (req_table == mirb_pkg::TBL_COIL);
   assign wr_hold = req_valid && req_write && (req_table == mirb_pkg::TBL_HOLDING)
                    && (req_addr == mirb_pkg::HOLD_NODE_ADDR);
   assign restart_evt = wr_coil && (req_addr == mirb_pkg::COIL_CTRL_RESTART)
                        && req_wdata[0];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.rsp_valid = req_valid;
      nxt_st.rsp_data  = 16'h0000;
      nxt_st.rsp_exc   = mirb_pkg::EXC_NONE;
      nxt_st.restart   = 1'b0;
      nxt_st.warn      = warn_in;

      // request decode; the answer follows one edge later
      if (req_valid) begin
         unique case (req_table)
            mirb_pkg::TBL_COIL: begin
               if (req_addr > mirb_pkg::COIL_LAST) begin
                  nxt_st.rsp_exc = mirb_pkg::EXC_ILL_ADDR;
               end else if (!req_write) begin
                  unique case (req_addr[2:0])
                     3'h0:    nxt_st.rsp_data = {15'h0000, st_ff.reset_warn};
                     3'h1:    nxt_st.rsp_data = {15'h0000, st_ff.standby};
                     3'h3:    nxt_st.rsp_data = {15'h0000, st_ff.warn_hold};
                     default: nxt_st.rsp_data = 16'h0000;   // action coils read 0
                  endcase
               end else begin
                  nxt_st.rsp_data = req_wdata;
               end
            end
            mirb_pkg::TBL_DISCRETE: begin
               if (req_write) begin
                  nxt_st.rsp_exc = mirb_pkg::EXC_ILL_FUNC;
               end else if (req_addr > mirb_pkg::DI_LAST) begin
                  nxt_st.rsp_exc = mirb_pkg::EXC_ILL_ADDR;
               end else begin
                  nxt_st.rsp_data = {15'h0000, di_bits[req_addr[2:0]]};
               end
            end
            mirb_pkg::TBL_HOLDING: begin
               if (req_addr != mirb_pkg::HOLD_NODE_ADDR) begin
                  nxt_st.rsp_exc = mirb_pkg::EXC_ILL_ADDR;
               end else if (!req_write) begin
                  nxt_st.rsp_data = {8'h00, st_ff.node_addr};
               end else if (req_wdata < {8'h00, mirb_pkg::NODE_ADDR_MIN} ||
                            req_wdata > {8'h00, mirb_pkg::NODE_ADDR_MAX}) begin
                  nxt_st.rsp_exc = mirb_pkg::EXC_ILL_VALUE;
               end else begin
                  nxt_st.rsp_data  = req_wdata;
                  nxt_st.node_addr = req_wdata[7:0];
               end
            end
            mirb_pkg::TBL_INPUT: begin
               if (req_write) begin
                  nxt_st.rsp_exc = mirb_pkg::EXC_ILL_FUNC;
               end else if (!rd_word_ok) begin
                  nxt_st.rsp_exc = mirb_pkg::EXC_ILL_ADDR;
               end else begin
                  nxt_st.rsp_data = req_addr[0] ? rd_word[15:0] : rd_word[31:16];
               end
            end
         endcase
      end

      // coil actions
      if (wr_coil && req_addr == mirb_pkg::COIL_PUMP_STANDBY) begin
         nxt_st.standby = req_wdata[0];
      end
      nxt_st.pump_en = !nxt_st.standby;   // own flop, so the pin has no gate after it
      if (wr_coil && req_addr == mirb_pkg::COIL_WARN_HOLD) begin
         nxt_st.warn_hold = req_wdata[0];
      end
      nxt_st.restart = restart_evt;

      // reset warning: warm-up clear, write, then restart set wins
      if (warmup_end && !st_ff.warn_hold) begin
         nxt_st.reset_warn = 1'b0;
      end
      if (wr_coil && req_addr == mirb_pkg::COIL_RESET_WARN) begin
         nxt_st.reset_warn = req_wdata[0];
      end
      if (restart_evt) begin
         nxt_st.reset_warn = 1'b1;
      end

      // service countdown runs on pump operating hours only
      if (!st_ff.standby && st_ff.hours_left != 16'h0000) begin
         if (st_ff.hour_cnt >= HOUR_CYCLES - 40'h1) begin
            nxt_st.hour_cnt   = 40'h0;
            nxt_st.hours_left = st_ff.hours_left - 16'h0001;
         end else begin
            nxt_st.hour_cnt = st_ff.hour_cnt + 40'h1;
         end
      end
      if (st_ff.hours_left == 16'h0000) begin
         nxt_st.reminder = 1'b1;
      end
      // reload removes the cause, so the reload takes precedence here
      if (wr_coil && req_addr == mirb_pkg::COIL_SVC_RESTART && req_wdata[0]) begin
         nxt_st.reminder   = 1'b0;
         nxt_st.hours_left = SVC_HOURS;
         nxt_st.hour_cnt   = 40'h0;
      end

      // transport select, never both enabled
      nxt_st.serial_en = !transport_net;
      nxt_st.net_en    = transport_net;

      // serial bit-rate enable for the framing layer
      nxt_st.baud_tick = 1'b0;
      if (st_ff.baud_cnt >= mirb_pkg::BAUD_CYCLES - 12'h001) begin
         nxt_st.baud_cnt  = 12'h000;
         nxt_st.baud_tick = st_ff.serial_en;
      end else begin
         nxt_st.baud_cnt = st_ff.baud_cnt + 12'h001;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // power-up is itself a restart, hence warning reset value of one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff            <= '0;
         st_ff.reset_warn <= mirb_pkg::RESET_WARN_RST;
         st_ff.node_addr  <= mirb_pkg::NODE_ADDR_RST;
         st_ff.hours_left <= SVC_HOURS;
         st_ff.serial_en  <= 1'b1;
         st_ff.pump_en    <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rsp_valid        = st_ff.rsp_valid;
   assign rsp_data         = st_ff.rsp_data;
   assign rsp_exc          = st_ff.rsp_exc;
   assign pump_enable      = st_ff.pump_en;
   assign ctrl_restart     = st_ff.restart;
   assign node_address     = st_ff.node_addr;
   assign serial_enable    = st_ff.serial_en;
   assign net_enable       = st_ff.net_en;
   assign serial_bit_tick  = st_ff.baud_tick;
   assign reset_warning    = st_ff.reset_warn;
   assign service_reminder = st_ff.reminder;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_addr_default;
      @(posedge clk) $past(!rst_n) |-> node_address == mirb_pkg::NODE_ADDR_RST;
   endproperty
   a_addr_default: assert property (p_addr_default)
      else $error("node address not 1 after reset");

   property p_addr_range;
      @(posedge clk) disable iff (!rst_n)
      (wr_hold && (req_wdata == 16'h0000 || req_wdata > 16'h00f7))
      |=> rsp_exc == mirb_pkg::EXC_ILL_VALUE && $stable(node_address);
   endproperty
   a_addr_range: assert property (p_addr_range)
      else $error("out of range address accepted");

   property p_addr_now;
      @(posedge clk) disable iff (!rst_n)
      (wr_hold && req_wdata >= 16'h0001 && req_wdata <= 16'h00f7)
      |=> node_address == $past(req_wdata[7:0]);
   endproperty
   a_addr_now: assert property (p_addr_now)
      else $error("node address not applied at once");

   property p_restart_warn;
      @(posedge clk) disable iff (!rst_n)
      restart_evt |=> ctrl_restart && reset_warning ##1 (!ctrl_restart || $past(restart_evt));
   endproperty
   a_restart_warn: assert property (p_restart_warn)
      else $error("restart did not pulse or set warning");

   property p_warn_held;
      @(posedge clk) disable iff (!rst_n)
      (st_ff.warn_hold && reset_warning && warmup_end && !wr_coil) |=> reset_warning;
   endproperty
   a_warn_held: assert property (p_warn_held)
      else $error("held warning cleared by warm-up");

   property p_warn_auto;
      @(posedge clk) disable iff (!rst_n)
      (!st_ff.warn_hold && warmup_end && !wr_coil) |=> !reset_warning;
   endproperty
   a_warn_auto: assert property (p_warn_auto)
      else $error("warning not cleared at warm-up end");

   property p_standby;
      @(posedge clk) disable iff (!rst_n)
      (wr_coil && req_addr == mirb_pkg::COIL_PUMP_STANDBY)
      |=> pump_enable == !$past(req_wdata[0]);
   endproperty
   a_standby: assert property (p_standby)
      else $error("pump enable does not follow standby coil");

   property p_reminder;
      @(posedge clk) disable iff (!rst_n)
      (st_ff.hours_left == 16'h0000 && !wr_coil) |=> service_reminder;
   endproperty
   a_reminder: assert property (p_reminder)
      else $error("reminder not set at zero hours");

   property p_svc_restart;
      @(posedge clk) disable iff (!rst_n)
      (wr_coil && req_addr == mirb_pkg::COIL_SVC_RESTART && req_wdata[0])
      |=> !service_reminder && st_ff.hours_left == SVC_HOURS;
   endproperty
   a_svc_restart: assert property (p_svc_restart)
      else $error("service restart did not reload");

   property p_one_transport;
      @(posedge clk) disable iff (!rst_n) !(serial_enable && net_enable);
   endproperty
   a_one_transport: assert property (p_one_transport)
      else $error("both transports enabled");

   property p_answer;
      @(posedge clk) disable iff (!rst_n) req_valid |=> rsp_valid ##1 $past(req_valid) == rsp_valid;
   endproperty
   a_answer: assert property (p_answer)
      else $error("answer not one cycle after request");

   c_standby:  cover property (@(posedge clk) disable iff (!rst_n) $fell(pump_enable));
   c_reminder: cover property (@(posedge clk) disable iff (!rst_n) $rose(service_reminder));
   c_restart:  cover property (@(posedge clk) disable iff (!rst_n) ctrl_restart);
   c_bad_addr: cover property (@(posedge clk) disable iff (!rst_n)
                               rsp_exc == mirb_pkg::EXC_ILL_VALUE);

endmodule : mirb_register_bank

// ### tb/mirb_master_model.sv
// remote master model issuing one request at a time
`timescale 1ns/1ps
module mirb_master_model (
   input  wire logic        clk,
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_data,
   input  wire logic [7:0]  rsp_exc,
   output logic             req_valid,
   output logic             req_write,
   output logic [1:0]       req_table,
   output logic [15:0]      req_addr,
   output logic [15:0]      req_wdata
);
   // -----------------------------------------------
   // request launched after an edge, answer one edge later
   // -----------------------------------------------
   task automatic xfer(input logic w, input logic [1:0] t, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] q, output logic [7:0] e,
                       output logic v);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_table <= t;
      req_addr  <= a;
      req_wdata <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      req_addr  <= ~a;  // released address and data carry junk, never the old value
      req_wdata <= ~d;
      #1;
      q = rsp_data;
      e = rsp_exc;
      v = rsp_valid;
   endtask : xfer

   // idle bus at time zero
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_table = 2'h0;
      req_addr  = 16'h0000;
      req_wdata = 16'h0000;
   end
endmodule : mirb_master_model

// ### tb/mirb_register_bank_tb_top.sv
// self-checking bench for the instrument register bank
`timescale 1ns/1ps
module mirb_register_bank_tb_top;
   localparam logic [1:0]  TC = mirb_pkg::TBL_COIL;
   localparam logic [1:0]  TD = mirb_pkg::TBL_DISCRETE;
   localparam logic [1:0]  TH = mirb_pkg::TBL_HOLDING;
   localparam logic [1:0]  TI = mirb_pkg::TBL_INPUT;
   // identity words, arbitrary values
   localparam logic [31:0] IDV [4] = '{32'h1234abcd, 32'h0000beef, 32'h00c0ffee, 32'h40a00000};
   logic        clk, rst_n, warmup_end, transport_net;
   logic [5:0]  warn_in;
   logic [31:0] fv [7];
   logic        req_valid, req_write, rsp_valid, pump_enable, ctrl_restart;
   logic [1:0]  req_table;
   logic [15:0] req_addr, req_wdata, rsp_data;
   logic [7:0]  rsp_exc, node_address;
   logic        serial_enable, net_enable, reset_warning, service_reminder, serial_bit_tick;
   int          n_errors, total_checks, cyc, k;

   // ----------------------------------------------
   // clock, design and master
   // ----------------------------------------------
   initial clk = 1'b0;
   always #4 clk = ~clk;

   // short hour and interval keep the countdown within a few hundred cycles
   mirb_register_bank #(.HOUR_CYCLES(40'd20), .SVC_HOURS(16'h0003), .MODEL_CODE(IDV[0]),
      .UNIT_SERIAL(IDV[1]), .FW_PART(IDV[2]), .FW_VERSION(IDV[3])) uut (
      .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
      .req_table(req_table), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_exc(rsp_exc),
      .warmup_end(warmup_end), .warn_in(warn_in), .transport_net(transport_net),
      .tank_pressure(fv[0]), .outlet_pressure(fv[1]), .scrub_temp(fv[2]),
      .encl_temp(fv[3]), .pump_duty(fv[4]), .heater_duty(fv[5]), .ref_voltage(fv[6]),
      .pump_enable(pump_enable), .ctrl_restart(ctrl_restart), .node_address(node_address),
      .serial_enable(serial_enable), .net_enable(net_enable),
      .serial_bit_tick(serial_bit_tick),
      .reset_warning(reset_warning), .service_reminder(service_reminder));

   mirb_master_model mst (
      .clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_exc(rsp_exc),
      .req_valid(req_valid), .req_write(req_write), .req_table(req_table),
      .req_addr(req_addr), .req_wdata(req_wdata));

   // ----------------------------------------------
   // comparison, request and closing tasks
   // ----------------------------------------------
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask : chk

   // exceptions carry no data, so data is only compared on good answers
   task automatic op(input logic w, input logic [1:0] t, input logic [15:0] a,
                     input logic [15:0] d, input logic [15:0] xd, input logic [7:0] xe);
      logic [15:0] q;
      logic [7:0]  e;
      logic        v;
      mst.xfer(w, t, a, d, q, e, v);
      chk("rsp_valid", {31'h0, v}, 32'h1);
      chk("rsp_exc", {24'h0, e}, {24'h0, xe});
      if (xe === 8'h00) chk("rsp_data", {16'h0, q}, {16'h0, xd});
   endtask : op

   task automatic pulse_warm();
      @(posedge clk);
      warmup_end <= 1'b1;
      @(posedge clk);
      warmup_end <= 1'b0;
      @(posedge clk);
      #1;
   endtask : pulse_warm

   // steps one cycle first, so a tick still standing is not counted twice
   task automatic wait_tick();
      @(posedge clk);
      #1;
      for (int i = 0; i < 2500 && serial_bit_tick !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
   endtask : wait_tick

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   // hang guard above two bit periods plus a few hundred cycles of traffic
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         summarize();
      end
   end

   // ----------------------------------------------
   // main sequence
   // ----------------------------------------------
   initial begin
      rst_n = 1'b0;
      warmup_end = 1'b0;
      transport_net = 1'b0;
      warn_in = 6'h2d;
      fv = '{32'h41200000, 32'h40a00000, 32'h42480000, 32'h41f00000, 32'h3f800000,
             32'h3f000000, 32'h45800000};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("reset_warning", 32'(reset_warning), 32'h1);
      chk("node_address", 32'(node_address), 32'h1);
      op(1'b0, TI, 16'h000c, 16'h0, 16'h4040, 8'h00);
      op(1'b0, TC, 16'h0000, 16'h0, 16'h0001, 8'h00);
      pulse_warm();
      chk("reset_warning", 32'(reset_warning), 32'h0);
      op(1'b1, TC, 16'h0000, 16'h1, 16'h0001, 8'h00);
      op(1'b1, TC, 16'h0003, 16'h1, 16'h0001, 8'h00);
      pulse_warm();
      chk("reset_warning", 32'(reset_warning), 32'h1);
      op(1'b1, TC, 16'h0000, 16'h0, 16'h0000, 8'h00);
      chk("reset_warning", 32'(reset_warning), 32'h0);
      op(1'b1, TC, 16'h0003, 16'h0, 16'h0000, 8'h00);
      op(1'b1, TC, 16'h0001, 16'h1, 16'h0001, 8'h00);
      chk("pump_enable", 32'(pump_enable), 32'h0);
      op(1'b0, TC, 16'h0001, 16'h0, 16'h0001, 8'h00);
      op(1'b1, TC, 16'h0001, 16'h0, 16'h0000, 8'h00);
      chk("pump_enable", 32'(pump_enable), 32'h1);
      op(1'b1, TC, 16'h0005, 16'h1, 16'h0000, 8'h02);
      for (k = 1; k <= 6; k++) op(1'b0, TD, 16'(k), 16'h0, {15'h0, warn_in[k-1]}, 8'h00);
      op(1'b0, TD, 16'h0007, 16'h0, 16'h0000, 8'h02);
      op(1'b1, TD, 16'h0001, 16'h1, 16'h0000, 8'h01);
      op(1'b1, TH, 16'h0000, 16'd0, 16'h0000, 8'h03);
      op(1'b1, TH, 16'h0000, 16'd248, 16'h0000, 8'h03);
      chk("node_address", 32'(node_address), 32'h1);
      op(1'b1, TH, 16'h0000, 16'd247, 16'd247, 8'h00);
      chk("node_address", 32'(node_address), 32'd247);
      op(1'b0, TH, 16'h0000, 16'h0, 16'd247, 8'h00);
      op(1'b1, TH, 16'h0000, 16'd1, 16'd1, 8'h00);
      op(1'b0, TH, 16'h0001, 16'h0, 16'h0000, 8'h02);
      for (k = 0; k < 7; k++) begin
         op(1'b0, TI, 16'(2*k + (k == 6 ? 2 : 0)), 16'h0, fv[k][31:16], 8'h00);
         op(1'b0, TI, 16'(2*k + (k == 6 ? 3 : 1)), 16'h0, fv[k][15:0], 8'h00);
      end
      for (k = 0; k < 4; k++) begin
         op(1'b0, TI, 16'(30 + 2*k), 16'h0, IDV[k][31:16], 8'h00);
         op(1'b0, TI, 16'(31 + 2*k), 16'h0, IDV[k][15:0], 8'h00);
      end
      op(1'b0, TI, 16'h0010, 16'h0, 16'h0000, 8'h02);
      op(1'b1, TI, 16'h0000, 16'h1, 16'h0000, 8'h01);
      for (k = 0; k < 300 && service_reminder !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk("service_reminder", 32'(service_reminder), 32'h1);
      op(1'b0, TD, 16'h0000, 16'h0, 16'h0001, 8'h00);
      op(1'b0, TI, 16'h000c, 16'h0, 16'h0000, 8'h00);
      op(1'b1, TC, 16'h0002, 16'h1, 16'h0001, 8'h00);
      chk("service_reminder", 32'(service_reminder), 32'h0);
      op(1'b0, TI, 16'h000c, 16'h0, 16'h4040, 8'h00);
      pulse_warm();
      op(1'b1, TC, 16'h0004, 16'h1, 16'h0001, 8'h00);
      chk("ctrl_restart", 32'(ctrl_restart), 32'h1);
      chk("reset_warning", 32'(reset_warning), 32'h1);
      op(1'b0, TC, 16'h0004, 16'h0, 16'h0000, 8'h00);
      // two bit-rate ticks one bit period apart while serial is selected
      wait_tick();
      k = cyc;
      wait_tick();
      chk("serial_bit_tick period", 32'(cyc - k), 32'(mirb_pkg::BAUD_CYCLES));
      @(posedge clk);
      transport_net <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("net_enable", 32'(net_enable), 32'h1);
      chk("serial_enable", 32'(serial_enable), 32'h0);
      summarize();
   end
endmodule : mirb_register_bank_tb_top
